// File: bench/pfm_pads.sv
// Far-side pin model: external drivers, pull-ups and floating pins.
// Assumes one clock; a pin the design drives shows the design's value.
`timescale 1ns/1ns
module pfm_pads #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic [WIDTH-1:0] pin_out,
   input  wire logic [WIDTH-1:0] pin_oe,
   input  wire logic [WIDTH-1:0] ext_val,
   input  wire logic [WIDTH-1:0] ext_en,
   input  wire logic [WIDTH-1:0] pull_up,
   output logic      [WIDTH-1:0] level
);
   logic [WIDTH-1:0] last_q = '0;
   ////////////////////////////////////////////////////////////////////////
   // Floating pins flip each cycle so stale levels never read back
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (pin_oe[i])
            level[i] = pin_out[i];
         else if (ext_en[i])
            level[i] = ext_val[i];
         else if (pull_up[i])
            level[i] = 1'h1;
         else
            level[i] = ~last_q[i];
      end
   end
   always_ff @(posedge clock) begin
      last_q <= level;
   end
endmodule

// File: bench/tb.sv
// Self-checking bench for the port pin-function mux.
// Assumes the pad model on every port; inputs change on falling edges.
`timescale 1ns/1ns
module tb;
   import pfm_pkg::*;
   logic clock = 0, reset_n = 0, expanded_mode = 0;
   logic port_k_emulation_enable = 0, port_k_pullup_enable = 1;
   logic emulation_chip_select_n = 1, external_chip_select_n = 1;
   logic i2c_enable = 0, i2c_scl_low = 0, i2c_sda_low = 0;
   logic serial2_tx_enable = 0, serial2_transmit = 0, serial2_rx_enable = 0;
   logic dac_one_enable = 0, dac_two_enable = 0;
   logic pwm_enable = 0, pwm_all_select = 0;
   logic current_status_enable = 0, fault_input_enable = 0;
   logic spi_enable = 0, spi_master = 0, spi_ss_drive = 0, spi_ss_out = 0;
   logic spi_sck_out = 0, spi_mosi_out = 0, spi_miso_out = 0;
   logic port_k_pullup_on, onchip_memory_enable, keypad_wakeup;
   logic i2c_scl_in, i2c_sda_in, serial2_receive;
   logic dac_one_output, dac_two_output;
   logic spi_ss_in, spi_sck_in, spi_mosi_in, spi_miso_in;
   logic [2:0] pwm_pair_select = '0, current_status_inputs_n;
   logic [3:0] fault_inputs;
   logic [5:0] fault_pwm_outputs = '0;
   pfm_extended_address_type extended_address = '0;
   logic [7:0] k_gpio_out = '0, k_gpio_dir = '0, k_pin_in, k_pin_out, k_pin_oe;
   logic [7:0] m_gpio_out = '0, m_gpio_dir = '0, m_pin_in, m_pin_out, m_pin_oe;
   logic [7:0] s_gpio_out = '0, s_gpio_dir = '0, s_pin_in, s_pin_out, s_pin_oe;
   logic [5:0] p_gpio_out = '0, p_gpio_dir = '0, p_pin_in, p_pin_out, p_pin_oe;
   logic [6:0] q_gpio_out = '0, q_gpio_dir = '0, q_pin_in, q_pin_out, q_pin_oe;
   logic [15:0] ad_gpio_out = '0, ad_gpio_dir = '0, ad_pin_in, ad_pin_out;
   logic [15:0] ad_digital_enable = '0, ad_wakeup_enable = '0;
   logic [15:0] ad_wakeup_clear = '0, ad_pin_oe, ad_analog_select;
   logic [15:0] analog_port_wakeup, ad_ext = '0, ad_ext_en = '0;
   logic [7:0] k_ext = 8'h80, k_ext_en = 8'h80, m_ext = '0, m_ext_en = '0;
   logic [7:0] s_ext = '0, s_ext_en = '0;
   logic [5:0] p_ext = '0, p_ext_en = '0;
   logic [6:0] q_ext = '0, q_ext_en = '0;
   int n_errors = 0, num_checks = 0;
   ////////////////////////////////////////////////////////////////////////
   always #50 clock = ~clock;
   pfm_mux DUT (.*);
   pfm_pads #(.WIDTH(8)) pads_k (.clock(clock), .pin_out(k_pin_out),
      .pin_oe(k_pin_oe), .ext_val(k_ext), .ext_en(k_ext_en),
      .pull_up({8{port_k_pullup_on}}), .level(k_pin_in));
   pfm_pads #(.WIDTH(8)) pads_m (.clock(clock), .pin_out(m_pin_out),
      .pin_oe(m_pin_oe), .ext_val(m_ext), .ext_en(m_ext_en),
      .pull_up(8'h00), .level(m_pin_in));
   pfm_pads #(.WIDTH(8)) pads_s (.clock(clock), .pin_out(s_pin_out),
      .pin_oe(s_pin_oe), .ext_val(s_ext), .ext_en(s_ext_en),
      .pull_up(8'h00), .level(s_pin_in));
   pfm_pads #(.WIDTH(6)) pads_p (.clock(clock), .pin_out(p_pin_out),
      .pin_oe(p_pin_oe), .ext_val(p_ext), .ext_en(p_ext_en),
      .pull_up(6'h00), .level(p_pin_in));
   pfm_pads #(.WIDTH(7)) pads_q (.clock(clock), .pin_out(q_pin_out),
      .pin_oe(q_pin_oe), .ext_val(q_ext), .ext_en(q_ext_en),
      .pull_up(7'h00), .level(q_pin_in));
   pfm_pads #(.WIDTH(16)) pads_ad (.clock(clock), .pin_out(ad_pin_out),
      .pin_oe(ad_pin_oe), .ext_val(ad_ext), .ext_en(ad_ext_en),
      .pull_up(16'h0000), .level(ad_pin_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // No open-ended wait: a hang ends here
   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      $display("Error at %0t: run timed out", $time);
      conclude;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(4);
      chk({k_pin_oe, m_pin_oe}, 16'h0000);
      chk({p_pin_oe, q_pin_oe, s_pin_oe[1:0]}, 16'h0000);
      chk(port_k_pullup_on, 16'h1);
      reset_n = 1;
      cyc(1);
      chk(onchip_memory_enable, 16'h1);
      chk({s_pin_oe, m_pin_oe}, 16'h0000);
      k_ext_en = 8'h00;
      expanded_mode = 1;
      port_k_emulation_enable = 1;
      emulation_chip_select_n = 0;
      extended_address = 6'h2a;
      cyc(2);
      chk(k_pin_oe, 16'hff);
      chk(k_pin_out, 16'h6a);
      emulation_chip_select_n = 1;
      external_chip_select_n = 0;
      extended_address = 6'h15;
      cyc(1);
      chk(k_pin_out, 16'h95);
      port_k_emulation_enable = 0;
      k_gpio_dir = 8'h0f;
      k_gpio_out = 8'h05;
      port_k_pullup_enable = 0;
      cyc(1);
      chk(k_pin_oe, 16'h0f);
      chk(k_pin_out & k_pin_oe, 16'h05);
      chk(port_k_pullup_on, 16'h0);
      $display("Test port_k finished");
      i2c_enable = 1;
      i2c_scl_low = 1;
      serial2_tx_enable = 1;
      serial2_transmit = 1;
      serial2_rx_enable = 1;
      dac_one_enable = 1;
      dac_two_enable = 1;
      m_gpio_dir = 8'hff;
      m_ext_en = 8'h50;
      cyc(3);
      chk(m_pin_oe, 16'hac);
      chk(m_pin_out & m_pin_oe, 16'h20);
      chk({i2c_scl_in, i2c_sda_in, serial2_receive}, 16'h0);
      chk({dac_one_output, dac_two_output}, 16'h3);
      m_ext = 8'h90;
      m_ext_en = 8'hd0;
      {i2c_scl_low, i2c_sda_low} = 2'h1;
      serial2_transmit = 0;
      cyc(3);
      chk({i2c_scl_in, i2c_sda_in, serial2_receive}, 16'h5);
      chk(m_pin_out & m_pin_oe, 16'h00);
      chk(m_pin_oe, 16'h6c);
      m_ext_en = 8'h00;
      {i2c_enable, serial2_tx_enable, serial2_rx_enable} = 3'h0;
      {dac_one_enable, dac_two_enable} = 2'h0;
      m_gpio_out = 8'h0c;
      cyc(3);
      chk(m_pin_oe, 16'hff);
      chk(m_pin_out, 16'h0c);
      chk({serial2_receive, dac_one_output, dac_two_output}, 16'h4);
      $display("Test port_m finished");
      pwm_enable = 1;
      pwm_all_select = 1;
      fault_pwm_outputs = 6'h2d;
      cyc(1);
      chk({p_pin_oe, p_pin_out}, 16'h0fed);
      pwm_all_select = 0;
      pwm_pair_select = 3'h1;
      p_gpio_dir = 6'h0c;
      p_gpio_out = 6'h04;
      cyc(1);
      chk({p_pin_oe, p_pin_out & p_pin_oe}, 16'h03c5);
      pwm_enable = 0;
      cyc(1);
      chk(p_pin_oe, 16'h0c);
      current_status_enable = 1;
      fault_input_enable = 1;
      q_ext = 7'h5a;
      q_ext_en = 7'h7f;
      q_gpio_dir = 7'h7f;
      cyc(3);
      chk(current_status_inputs_n, 16'h5);
      chk({fault_inputs, q_pin_oe}, 16'h500);
      {current_status_enable, fault_input_enable, q_ext_en} = '0;
      q_gpio_out = 7'h33;
      cyc(3);
      chk({current_status_inputs_n, fault_inputs}, 16'h70);
      chk(q_pin_oe, 16'h7f);
      chk(q_pin_out, 16'h33);
      $display("Test ports_p_q finished");
      spi_enable = 1;
      spi_master = 1;
      spi_ss_drive = 1;
      spi_sck_out = 1;
      spi_mosi_out = 1;
      spi_ss_out = 1;
      s_ext = 8'h10;
      s_ext_en = 8'h10;
      cyc(3);
      chk({s_pin_oe, s_pin_out & s_pin_oe}, 16'he0e0);
      chk(spi_miso_in, 16'h1);
      {spi_master, spi_ss_drive, spi_miso_out} = 3'h1;
      s_ext = 8'h20;
      s_ext_en = 8'he0;
      s_gpio_dir = 8'h0f;
      s_gpio_out = 8'h05;
      cyc(3);
      chk({s_pin_oe, s_pin_out & s_pin_oe}, 16'h1f15);
      chk({spi_ss_in, spi_sck_in, spi_mosi_in}, 16'h1);
      $display("Test port_s finished");
      ad_digital_enable = 16'h0003;
      ad_wakeup_enable = 16'h0001;
      ad_ext = 16'h0003;
      ad_ext_en = 16'hffff;
      ad_gpio_dir = 16'h0006;
      ad_gpio_out = 16'h0002;
      cyc(3);
      chk(ad_analog_select, 16'hfffc);
      chk(ad_pin_oe, 16'h0002);
      ad_ext = 16'h0000;
      cyc(4);
      chk(analog_port_wakeup, 16'h0001);
      chk(keypad_wakeup, 16'h1);
      ad_wakeup_clear = 16'h0001;
      cyc(1);
      ad_wakeup_clear = 16'h0000;
      cyc(1);
      chk(analog_port_wakeup, 16'h0000);
      chk(keypad_wakeup, 16'h0);
      reset_n = 0;
      k_ext = 8'h00;
      k_ext_en = 8'h80;
      cyc(1);
      chk({m_pin_oe, s_pin_oe}, 16'h0000);
      chk(port_k_pullup_on, 16'h1);
      cyc(2);
      reset_n = 1;
      cyc(1);
      chk(onchip_memory_enable, 16'h0);
      $display("Test wake_reset finished");
      conclude;
   end
endmodule

// File: core/pfm_mux.sv
// Pin-function mux for ports K, AD, M, P, Q and S.
// Assumes peripheral enables and port registers arrive on this clock.
//
// How it works
// - Expanded mode with emulation enable drives K7 as emulation select.
// - K7 level at reset release becomes on-chip memory enable.
// - Port K pull-ups on in and after reset, off when bit cleared.
// - Same condition drives K6 as the external chip select.
// - Same condition drives address bits 19..14 on K5..K0.
// - AD pins analog or digital; digital pins give keypad wake-up.
// - Enabled I2C takes M7 as clock line and M6 as data.
// - M5 transmits when serial transmitter on; M4 receives when receiver on.
// - Converter one owns M1, converter two owns M0 when enabled.
// - Enabled fault PWM drives P5..P0, all together or by pairs.
// - Q6..Q4 become active-low current status inputs when enabled.
// - Q3..Q0 become the four fault inputs when enabled.
// - Enabled SPI: S7 select, S6 clock, S5 data out master/in slave.
// - Ports M, P, Q, S stay undriven in and right after reset.
// - Enabled SPI: S4 data in as master, out as slave.
`timescale 1ns/1ns
`include "pfm_params.svh"
module pfm_mux (
   input  wire logic                    clock,
   input  wire logic                    reset_n,
   input  wire logic                    expanded_mode,
   input  wire logic                    port_k_emulation_enable,
   input  wire logic                    port_k_pullup_enable,
   input  wire logic                    emulation_chip_select_n,
   input  wire logic                    external_chip_select_n,
   input  wire pfm_pkg::pfm_extended_address_type  extended_address,
   input  wire logic [`PFM_K_WIDTH-1:0]  k_gpio_out,
   input  wire logic [`PFM_K_WIDTH-1:0]  k_gpio_dir,
   input  wire logic [`PFM_K_WIDTH-1:0]  k_pin_in,
   output logic      [`PFM_K_WIDTH-1:0]  k_pin_out,
   output logic      [`PFM_K_WIDTH-1:0]  k_pin_oe,
   output logic                         port_k_pullup_on,
   output logic                         onchip_memory_enable,
   input  wire logic [`PFM_AD_WIDTH-1:0] ad_digital_enable,
   input  wire logic [`PFM_AD_WIDTH-1:0] ad_wakeup_enable,
   input  wire logic [`PFM_AD_WIDTH-1:0] ad_wakeup_clear,
   input  wire logic [`PFM_AD_WIDTH-1:0] ad_gpio_out,
   input  wire logic [`PFM_AD_WIDTH-1:0] ad_gpio_dir,
   input  wire logic [`PFM_AD_WIDTH-1:0] ad_pin_in,
   output logic      [`PFM_AD_WIDTH-1:0] ad_pin_out,
   output logic      [`PFM_AD_WIDTH-1:0] ad_pin_oe,
   output logic      [`PFM_AD_WIDTH-1:0] ad_analog_select,
   output logic      [`PFM_AD_WIDTH-1:0] analog_port_wakeup,
   output logic                         keypad_wakeup,
   input  wire logic                    i2c_enable,
   input  wire logic                    i2c_scl_low,
   input  wire logic                    i2c_sda_low,
   output logic                         i2c_scl_in,
   output logic                         i2c_sda_in,
   input  wire logic                    serial2_tx_enable,
   input  wire logic                    serial2_transmit,
   input  wire logic                    serial2_rx_enable,
   output logic                         serial2_receive,
   input  wire logic                    dac_one_enable,
   input  wire logic                    dac_two_enable,
   output logic                         dac_one_output,
   output logic                         dac_two_output,
   input  wire logic [`PFM_M_WIDTH-1:0]  m_gpio_out,
   input  wire logic [`PFM_M_WIDTH-1:0]  m_gpio_dir,
   input  wire logic [`PFM_M_WIDTH-1:0]  m_pin_in,
   output logic      [`PFM_M_WIDTH-1:0]  m_pin_out,
   output logic      [`PFM_M_WIDTH-1:0]  m_pin_oe,
   input  wire logic                    pwm_enable,
   input  wire logic                    pwm_all_select,
   input  wire logic [2:0]              pwm_pair_select,
   input  wire logic [`PFM_P_WIDTH-1:0]  fault_pwm_outputs,
   input  wire logic [`PFM_P_WIDTH-1:0]  p_gpio_out,
   input  wire logic [`PFM_P_WIDTH-1:0]  p_gpio_dir,
   input  wire logic [`PFM_P_WIDTH-1:0]  p_pin_in,
   output logic      [`PFM_P_WIDTH-1:0]  p_pin_out,
   output logic      [`PFM_P_WIDTH-1:0]  p_pin_oe,
   input  wire logic                    current_status_enable,
   input  wire logic                    fault_input_enable,
   output logic      [2:0]              current_status_inputs_n,
   output logic      [3:0]              fault_inputs,
   input  wire logic [`PFM_Q_WIDTH-1:0]  q_gpio_out,
   input  wire logic [`PFM_Q_WIDTH-1:0]  q_gpio_dir,
   input  wire logic [`PFM_Q_WIDTH-1:0]  q_pin_in,
   output logic      [`PFM_Q_WIDTH-1:0]  q_pin_out,
   output logic      [`PFM_Q_WIDTH-1:0]  q_pin_oe,
   input  wire logic                    spi_enable,
   input  wire logic                    spi_master,
   input  wire logic                    spi_ss_drive,
   input  wire logic                    spi_ss_out,
   input  wire logic                    spi_sck_out,
   input  wire logic                    spi_mosi_out,
   input  wire logic                    spi_miso_out,
   output logic                         spi_ss_in,
   output logic                         spi_sck_in,
   output logic                         spi_mosi_in,
   output logic                         spi_miso_in,
   input  wire logic [`PFM_S_WIDTH-1:0]  s_gpio_out,
   input  wire logic [`PFM_S_WIDTH-1:0]  s_gpio_dir,
   input  wire logic [`PFM_S_WIDTH-1:0]  s_pin_in,
   output logic      [`PFM_S_WIDTH-1:0]  s_pin_out,
   output logic      [`PFM_S_WIDTH-1:0]  s_pin_oe
);
   import pfm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   pfm_phase_type phase_d, phase_q;
   logic active, emu_on, mem_en_d, mem_en_q, pull_d, pull_q;
   logic strap_meta_q, strap_q;
   logic [`PFM_K_WIDTH-1:0]  k_sel, k_alt, k_aoe;
   logic [`PFM_AD_WIDTH-1:0] ad_sync, ad_prev_d, ad_prev_q, wake_d, wake_q;
   logic [`PFM_AD_WIDTH-1:0] ad_dir;
   logic [`PFM_M_WIDTH-1:0]  m_sel, m_alt, m_aoe, m_sync;
   logic [`PFM_P_WIDTH-1:0]  p_sel;
   logic [`PFM_Q_WIDTH-1:0]  q_sel, q_sync;
   logic [`PFM_S_WIDTH-1:0]  s_sel, s_alt, s_aoe, s_sync;

   // Settle cycle keeps pins quiet right after release
   always_comb begin
      case (phase_q)
         PH_RESET: phase_d = PH_SETTLE;
         PH_SETTLE: phase_d = PH_RUN;
         PH_RUN: phase_d = PH_RUN;
         default: phase_d = PH_RESET;
      endcase
   end
   assign active = (phase_q == PH_RUN);
   assign emu_on = active & expanded_mode & port_k_emulation_enable;

   always_comb begin
      mem_en_d = mem_en_q;
      if (phase_q == PH_RESET)
         mem_en_d = strap_q;
      pull_d = port_k_pullup_enable;
   end

   always_ff @(posedge clock) begin
      // Strap sync runs through reset, else release latches a stale zero
      strap_meta_q <= k_pin_in[`PFM_K_EMU_CS];
      strap_q      <= strap_meta_q;
      if (!reset_n) begin
         phase_q      <= PH_RESET;
         mem_en_q     <= `PFM_MEM_EN_RESET;
         pull_q       <= `PFM_PULLUP_RESET;
      end else begin
         phase_q      <= phase_d;
         mem_en_q     <= mem_en_d;
         pull_q       <= pull_d;
      end
   end
   assign onchip_memory_enable = mem_en_q;
   assign port_k_pullup_on     = pull_q;

   ////////////////////////////////////////////////////////////////////////
   // Port K: bus signals
   assign k_sel = {`PFM_K_WIDTH{emu_on}};
   assign k_aoe = {`PFM_K_WIDTH{1'h1}};
   assign k_alt = {emulation_chip_select_n, external_chip_select_n,
                   extended_address};

   assign ad_dir = ad_gpio_dir & ad_digital_enable;
   assign ad_analog_select = ~ad_digital_enable;

   // falling edge wake, set beats clear
   always_comb begin
      ad_prev_d = ad_sync;
      wake_d = (wake_q & ~ad_wakeup_clear)
             | (ad_prev_q & ~ad_sync & ad_digital_enable & ad_wakeup_enable);
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         // Matches the sync reset value, so no false fall after reset
         ad_prev_q <= '0;
         wake_q    <= '0;
      end else begin
         ad_prev_q <= ad_prev_d;
         wake_q    <= wake_d;
      end
   end
   assign analog_port_wakeup = wake_q;
   assign keypad_wakeup      = |wake_q;

   ////////////////////////////////////////////////////////////////////////
   // port M selects
   always_comb begin
      m_sel = '0;
      m_alt = '0;
      m_aoe = '0;
      m_sel[`PFM_M_SCL]     = i2c_enable;
      m_sel[`PFM_M_SDA]     = i2c_enable;
      m_aoe[`PFM_M_SCL]     = i2c_scl_low;
      m_aoe[`PFM_M_SDA]     = i2c_sda_low;
      m_sel[`PFM_M_TXD]     = serial2_tx_enable;
      m_alt[`PFM_M_TXD]     = serial2_transmit;
      m_aoe[`PFM_M_TXD]     = 1'h1;
      m_sel[`PFM_M_RXD]     = serial2_rx_enable;
      m_sel[`PFM_M_DAC_ONE] = dac_one_enable;
      m_sel[`PFM_M_DAC_TWO] = dac_two_enable;
   end
   assign i2c_scl_in      = i2c_enable ? m_sync[`PFM_M_SCL] : 1'h1;
   assign i2c_sda_in      = i2c_enable ? m_sync[`PFM_M_SDA] : 1'h1;
   assign serial2_receive = serial2_rx_enable ? m_sync[`PFM_M_RXD] : 1'h1;
   assign dac_one_output  = active & dac_one_enable;
   assign dac_two_output  = active & dac_two_enable;

   assign p_sel = {`PFM_P_WIDTH{pwm_enable}}
                & ({`PFM_P_WIDTH{pwm_all_select}}
                 | {{2{pwm_pair_select[2]}}, {2{pwm_pair_select[1]}},
                    {2{pwm_pair_select[0]}}});

   assign q_sel = {{3{current_status_enable}}, {4{fault_input_enable}}};
   assign current_status_inputs_n = current_status_enable
      ? q_sync[`PFM_Q_IS_HI:`PFM_Q_IS_LO] : 3'h7;
   assign fault_inputs = fault_input_enable
      ? q_sync[`PFM_Q_FAULT_HI:0] : 4'h0;

   always_comb begin
      s_sel = '0;
      s_alt = '0;
      s_aoe = '0;
      s_sel[`PFM_S_SS]   = spi_enable;
      s_sel[`PFM_S_SCK]  = spi_enable;
      s_sel[`PFM_S_MOSI] = spi_enable;
      s_sel[`PFM_S_MISO] = spi_enable;
      s_alt[`PFM_S_SS]   = spi_ss_out;
      s_alt[`PFM_S_SCK]  = spi_sck_out;
      s_alt[`PFM_S_MOSI] = spi_mosi_out;
      s_alt[`PFM_S_MISO] = spi_miso_out;
      s_aoe[`PFM_S_SS]   = spi_master & spi_ss_drive;
      s_aoe[`PFM_S_SCK]  = spi_master;
      s_aoe[`PFM_S_MOSI] = spi_master;
      s_aoe[`PFM_S_MISO] = ~spi_master;
   end
   assign spi_ss_in   = spi_enable ? s_sync[`PFM_S_SS] : 1'h1;
   assign spi_sck_in  = spi_enable ? s_sync[`PFM_S_SCK] : 1'h0;
   assign spi_mosi_in = spi_enable ? s_sync[`PFM_S_MOSI] : 1'h0;
   assign spi_miso_in = spi_enable ? s_sync[`PFM_S_MISO] : 1'h0;

   ////////////////////////////////////////////////////////////////////////
   // registered pin drive
   pfm_pin_cell #(.WIDTH(`PFM_K_WIDTH)) cell_k (
      .clock(clock), .reset_n(reset_n), .active(active), .alt_sel(k_sel),
      .alt_out(k_alt), .alt_oe(k_aoe), .gpio_out(k_gpio_out),
      .gpio_dir(k_gpio_dir), .pin_in(k_pin_in), .pin_out(k_pin_out),
      .pin_oe(k_pin_oe), .in_sync());
   pfm_pin_cell #(.WIDTH(`PFM_AD_WIDTH)) cell_ad (
      .clock(clock), .reset_n(reset_n), .active(active),
      .alt_sel({`PFM_AD_WIDTH{1'h0}}), .alt_out({`PFM_AD_WIDTH{1'h0}}),
      .alt_oe({`PFM_AD_WIDTH{1'h0}}), .gpio_out(ad_gpio_out),
      .gpio_dir(ad_dir), .pin_in(ad_pin_in), .pin_out(ad_pin_out),
      .pin_oe(ad_pin_oe), .in_sync(ad_sync));
   pfm_pin_cell #(.WIDTH(`PFM_M_WIDTH)) cell_m (
      .clock(clock), .reset_n(reset_n), .active(active), .alt_sel(m_sel),
      .alt_out(m_alt), .alt_oe(m_aoe), .gpio_out(m_gpio_out),
      .gpio_dir(m_gpio_dir), .pin_in(m_pin_in), .pin_out(m_pin_out),
      .pin_oe(m_pin_oe), .in_sync(m_sync));
   pfm_pin_cell #(.WIDTH(`PFM_P_WIDTH)) cell_p (
      .clock(clock), .reset_n(reset_n), .active(active), .alt_sel(p_sel),
      .alt_out(fault_pwm_outputs), .alt_oe({`PFM_P_WIDTH{1'h1}}),
      .gpio_out(p_gpio_out), .gpio_dir(p_gpio_dir), .pin_in(p_pin_in),
      .pin_out(p_pin_out), .pin_oe(p_pin_oe), .in_sync());
   pfm_pin_cell #(.WIDTH(`PFM_Q_WIDTH)) cell_q (
      .clock(clock), .reset_n(reset_n), .active(active), .alt_sel(q_sel),
      .alt_out({`PFM_Q_WIDTH{1'h0}}), .alt_oe({`PFM_Q_WIDTH{1'h0}}),
      .gpio_out(q_gpio_out), .gpio_dir(q_gpio_dir), .pin_in(q_pin_in),
      .pin_out(q_pin_out), .pin_oe(q_pin_oe), .in_sync(q_sync));
   pfm_pin_cell #(.WIDTH(`PFM_S_WIDTH)) cell_s (
      .clock(clock), .reset_n(reset_n), .active(active), .alt_sel(s_sel),
      .alt_out(s_alt), .alt_oe(s_aoe), .gpio_out(s_gpio_out),
      .gpio_dir(s_gpio_dir), .pin_in(s_pin_in), .pin_out(s_pin_out),
      .pin_oe(s_pin_oe), .in_sync(s_sync));

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   emu_select_a: assert property (emu_on |=> k_pin_oe[7]
      && k_pin_out[7] == $past(emulation_chip_select_n))
      else $error("emulation select not on K7");
   strap_capture_a: assert property ($past(reset_n)
      && $past(phase_q) == PH_RESET |-> mem_en_q == $past(strap_q, 1))
      else $error("memory enable strap missed");
   strap_hold_a: assert property (phase_q == PH_RUN
      |=> $stable(mem_en_q))
      else $error("memory enable changed after release");
   pullup_reset_a: assert property ($rose(reset_n) |-> pull_q)
      else $error("port K pull-up off after reset");
   ext_select_a: assert property (emu_on |=> k_pin_oe[6]
      && k_pin_out[6] == $past(external_chip_select_n))
      else $error("external select not on K6");
   ext_addr_a: assert property (emu_on |=> k_pin_oe[5:0] == 6'h3f
      && k_pin_out[5:0] == $past(extended_address))
      else $error("extended address not on K");
   analog_quiet_a: assert property ((ad_gpio_dir & ~ad_digital_enable)
      != '0 |=> (ad_pin_oe & $past(ad_analog_select)) == '0)
      else $error("analog pin driven");
   i2c_hand_a: assert property (active && i2c_enable && i2c_sda_low
      |=> m_pin_oe[6] && !m_pin_out[6])
      else $error("I2C data low not driven");
   tx_hand_a: assert property (active && serial2_tx_enable
      |=> m_pin_oe[5] && m_pin_out[5] == $past(serial2_transmit))
      else $error("serial transmit not on M5");
   dac_free_a: assert property (active && dac_one_enable
      |=> !m_pin_oe[1])
      else $error("port drives converter output pin");
   pwm_pair_a: assert property (active && pwm_enable
      && pwm_pair_select[0] |=> p_pin_out[1:0] == $past(fault_pwm_outputs[1:0]))
      else $error("PWM pair not routed");
   status_in_a: assert property (current_status_enable
      && $past(reset_n) && $past(reset_n, 2)
      |-> current_status_inputs_n == $past(q_pin_in[6:4], 2))
      else $error("current status not routed");
   fault_in_a: assert property (!fault_input_enable
      |-> fault_inputs == 4'h0)
      else $error("fault input leaks while off");
   spi_role_a: assert property (active && spi_enable && !spi_master
      |=> !s_pin_oe[5] && !s_pin_oe[6])
      else $error("slave drives clock or data in");
   quiet_reset_a: assert property ($rose(reset_n) |-> ##1
      (m_pin_oe == '0 && p_pin_oe == '0 && q_pin_oe == '0 && s_pin_oe == '0))
      else $error("pins driven right after reset");
   miso_role_a: assert property (active && spi_enable && !spi_master
      |=> s_pin_oe[4] && s_pin_out[4] == $past(spi_miso_out))
      else $error("slave output not on S4");
   plain_gpio_a: assert property (active |=>
      m_pin_oe[3] == $past(m_gpio_dir[3]))
      else $error("plain pin ignores direction");

   emu_run_c: cover property (emu_on ##1 emu_on);
   spi_slave_c: cover property (active && spi_enable && !spi_master);
   wake_c: cover property ($rose(keypad_wakeup));
endmodule

// File: core/pfm_pin_cell.sv
// One port of pins: selects alternate or general-purpose drive and
// registers it, and synchronises the pin levels. Assumes one clock.
`timescale 1ns/1ns
module pfm_pin_cell #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic             active,
   input  wire logic [WIDTH-1:0] alt_sel,
   input  wire logic [WIDTH-1:0] alt_out,
   input  wire logic [WIDTH-1:0] alt_oe,
   input  wire logic [WIDTH-1:0] gpio_out,
   input  wire logic [WIDTH-1:0] gpio_dir,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe,
   output logic      [WIDTH-1:0] in_sync
);
   logic [WIDTH-1:0] out_d, out_q, oe_d, oe_q, meta_q, sync_q;

   always_comb begin
      out_d = '0;
      oe_d  = '0;
      // Alternate first, else port control
      if (active) begin
         out_d = (alt_sel & alt_out) | (~alt_sel & gpio_out);
         oe_d  = (alt_sel & alt_oe)  | (~alt_sel & gpio_dir);
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         out_q  <= '0;
         oe_q   <= '0;
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         out_q  <= out_d;
         oe_q   <= oe_d;
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign pin_out = out_q;
   assign pin_oe  = oe_q;
   assign in_sync = sync_q;
endmodule

// File: inc/pfm_params.svh
// Pin positions, widths and reset values for the port pin-function mux.
// Assumes inclusion by the package and by the design modules only.
`ifndef PFM_PARAMS_SVH
`define PFM_PARAMS_SVH
`define PFM_K_WIDTH         8
`define PFM_AD_WIDTH        16
`define PFM_M_WIDTH         8
`define PFM_P_WIDTH         6
`define PFM_Q_WIDTH         7
`define PFM_S_WIDTH         8
`define PFM_K_EMU_CS        7
`define PFM_K_EXT_CS        6
`define PFM_K_ADDR_HI       5
`define PFM_EXTENDED_ADDRESS_HI        19
`define PFM_EXTENDED_ADDRESS_LO        14
`define PFM_M_SCL           7
`define PFM_M_SDA           6
`define PFM_M_TXD           5
`define PFM_M_RXD           4
`define PFM_M_DAC_ONE       1
`define PFM_M_DAC_TWO       0
`define PFM_Q_IS_HI         6
`define PFM_Q_IS_LO         4
`define PFM_Q_FAULT_HI      3
`define PFM_S_SS            7
`define PFM_S_SCK           6
`define PFM_S_MOSI          5
`define PFM_S_MISO          4
`define PFM_MEM_EN_RESET    1'h0
`define PFM_PULLUP_RESET    1'h1
`endif

// File: inc/pfm_pkg.sv
// Types shared by the port pin-function mux modules.
// Assumes the params header is on the include path.
`include "pfm_params.svh"
package pfm_pkg;
   typedef enum logic [1:0] {PH_RESET, PH_SETTLE, PH_RUN} pfm_phase_type;
   typedef logic [`PFM_EXTENDED_ADDRESS_HI-`PFM_EXTENDED_ADDRESS_LO:0] pfm_extended_address_type;
endpackage
